// ===== hdl/adcs_pkg.sv
/*
 * adcs_pkg: register map, field positions and bus codes of the converter
 * start-source and result-register block.
 * assumes: 32-bit AXI4-Lite data, one 8-bit register per aligned word.
 */
package adcs_pkg;

	// =====================================================================
	// register map (printed offsets are indexes; byte address = 4 * (offset - base))
	localparam int          ADDR_W        = 8;
	localparam int          NUM_PAIRS     = 3;
	localparam int          RES_W         = 10;
	localparam logic [31:0] OFF_BASE      = 32'hfffff300;
	localparam logic [31:0] OFF_RES_LO [NUM_PAIRS] = '{32'hfffff300, 32'hfffff302, 32'hfffff304};
	localparam logic [31:0] OFF_RES_HI [NUM_PAIRS] = '{32'hfffff301, 32'hfffff303, 32'hfffff305};
	localparam logic [31:0] OFF_CTRL      = 32'hfffff31c;
	localparam logic [31:0] OFF_IRQ_STAT  = 32'hfffff320;
	localparam logic [31:0] OFF_IRQ_MASK  = 32'hfffff321;

	// =====================================================================
	// hw_start_and_soft_reset_ctrl fields
	localparam int          PRI_SEL_BIT   = 7;
	localparam int          PRI_EN_BIT    = 6;
	localparam int          NRM_SEL_BIT   = 5;
	localparam int          NRM_EN_BIT    = 4;
	localparam logic [1:0]  KEY_FIRST     = 2'h2;
	localparam logic [1:0]  KEY_SECOND    = 2'h1;

	// =====================================================================
	// result_low_reg fields
	localparam int          LO_STORED_BIT = 0;
	localparam int          LO_OVR_BIT    = 1;
	localparam logic [3:0]  LO_FILL       = 4'hf;

	// =====================================================================
	// interrupt status and mask layout
	localparam int          IRQ_W         = 4;
	localparam int          IRQ_NRM_START = 0;
	localparam int          IRQ_PRI_START = 1;
	localparam int          IRQ_STORED    = 2;
	localparam int          IRQ_OVERRUN   = 3;

	// =====================================================================
	// bus codes and states
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum {WR_IDLE, WR_HAVE_ADDR, WR_HAVE_DATA, WR_EXEC, WR_RESP} adcs_wr_state_type;
	typedef enum {RD_IDLE, RD_EXEC, RD_RESP} adcs_rd_state_type;

	function automatic logic [ADDR_W-1:0] reg_byte_addr(input logic [31:0] off);
		logic [31:0] byte_off;
		byte_off = (off - OFF_BASE) << 2;
		return byte_off[ADDR_W-1:0];
	endfunction : reg_byte_addr

	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction : rise

endpackage : adcs_pkg

// ===== hdl/adcs_hw_trigger.sv
/*
 * adcs_hw_trigger: picks the pin or the timer interrupt as hardware start
 * source and emits a one-cycle start pulse on its rising edge when enabled.
 * assumes: pin and interrupt inputs synchronous to clk.
 */
`timescale 1ns/100ps
module adcs_hw_trigger (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic src_timer,
	input  wire logic ext_pin,
	input  wire logic timer_irq,
	input  wire logic block,
	output logic      start_q
);
	import adcs_pkg::*;

	logic ext_prev_q;
	logic tmr_prev_q;
	wire  ext_edge = rise(ext_pin, ext_prev_q);
	wire  tmr_edge = rise(timer_irq, tmr_prev_q);
	wire  src_edge = src_timer ? tmr_edge : ext_edge;  // see [R2]

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_prev_q <= 1'b0;
			tmr_prev_q <= 1'b0;
			start_q    <= 1'b0;
		end else begin
			ext_prev_q <= ext_pin;
			tmr_prev_q <= timer_irq;
			start_q    <= enable & src_edge & ~block;  // see [R1]
		end
	end

endmodule : adcs_hw_trigger

// ===== hdl/adcs_result_pair.sv
/*
 * adcs_result_pair: one upper/lower result register pair with stored and
 * overrun flags cleared by reads.
 * assumes: load, rd_lo and rd_hi are one-cycle pulses.
 */
`timescale 1ns/100ps
module adcs_result_pair (
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	input  wire logic                         load,
	input  wire logic [adcs_pkg::RES_W-1:0]   value,
	input  wire logic                         rd_lo,
	input  wire logic                         rd_hi,
	output logic      [7:0]                   lo_byte,
	output logic      [7:0]                   hi_byte,
	output logic                              ovr_set
);
	import adcs_pkg::*;

	logic [RES_W-1:0] res_q;
	logic             stored_q;
	logic             ovr_q;
	logic             pend_lo_q;
	logic             pend_hi_q;

	// an unread half at load time means software lost a result
	assign ovr_set = load & (pend_lo_q | pend_hi_q);  // see [R11]
	assign hi_byte = res_q[RES_W-1:2];  // see [R7]
	assign lo_byte = {res_q[1:0], LO_FILL, ovr_q, stored_q};  // see [R7] see [R8]

	// result bits carry no reset: they are undefined until the first load
	always_ff @(posedge clk) begin
		if (load) begin
			res_q <= value;
		end
	end

	// set wins over a read in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stored_q  <= 1'b0;  // see [R12]
			ovr_q     <= 1'b0;
			pend_lo_q <= 1'b0;
			pend_hi_q <= 1'b0;
		end else begin
			stored_q  <= load | (stored_q & ~rd_lo);  // see [R9] see [R10]
			ovr_q     <= ovr_set | (ovr_q & ~rd_lo);  // see [R11] see [R12]
			pend_lo_q <= load | (pend_lo_q & ~rd_lo);
			pend_hi_q <= load | (pend_hi_q & ~rd_hi);
		end
	end

endmodule : adcs_result_pair

// ===== hdl/adcs_top.sv
/*
 * adcs_top: hardware start source selection, software reset key and
 * conversion result registers behind an AXI4-Lite slave, with interrupt.
 * assumes: converter core writes results through CONV_LOAD/CONV_PAIR/CONV_VALUE
 * and restarts on SOFT_RESET; all inputs synchronous to CLOCK.
 */
//
// Notes on behaviour
// [R1] hardware start accepted only while its enable bit (4 normal, 6 priority) is 1
// [R2] source select 0 picks trigger pin, 1 picks timer 0 or timer 1 interrupt
// [R3] software configures the shared pin as trigger input before enabling pin starts
// [R4] software selects timer source, then enables, then runs the timer
// [R5] software issues converter soft reset before switching start source
// [R6] software clears enable before giving the shared pin back to port use
// [R7] 10-bit result split: upper eight bits high register, two LSBs low bits 7:6
// [R8] low register bits 5 to 2 always read as ones
// [R9] stored flag set whenever a new result lands in the pair
// [R10] stored flag cleared when software reads the low register
// [R11] overrun set when a result lands before both halves were read
// [R12] overrun cleared by reading it; flags zero after reset, result undefined
// [R13] writing 10 then 01 to control bits 1:0 fires the converter soft reset
//
`timescale 1ns/100ps
module adcs_top (
	input  wire logic                            CLOCK,
	input  wire logic                            RST_N,
	// AXI4-Lite slave
	input  wire logic [adcs_pkg::ADDR_W-1:0]     S_AXI_AWADDR,
	input  wire logic                            S_AXI_AWVALID,
	output logic                                 S_AXI_AWREADY,
	input  wire logic [31:0]                     S_AXI_WDATA,
	input  wire logic [3:0]                      S_AXI_WSTRB,
	input  wire logic                            S_AXI_WVALID,
	output logic                                 S_AXI_WREADY,
	output logic [1:0]                           S_AXI_BRESP,
	output logic                                 S_AXI_BVALID,
	input  wire logic                            S_AXI_BREADY,
	input  wire logic [adcs_pkg::ADDR_W-1:0]     S_AXI_ARADDR,
	input  wire logic                            S_AXI_ARVALID,
	output logic                                 S_AXI_ARREADY,
	output logic [31:0]                          S_AXI_RDATA,
	output logic [1:0]                           S_AXI_RRESP,
	output logic                                 S_AXI_RVALID,
	input  wire logic                            S_AXI_RREADY,
	// start sources
	input  wire logic                            EXTERNAL_CONV_TRIGGER,
	input  wire logic                            TIMER0_IRQ,
	input  wire logic                            TIMER1_IRQ,
	// converter core
	input  wire logic                            CONV_LOAD,
	input  wire logic [1:0]                      CONV_PAIR,
	input  wire logic [adcs_pkg::RES_W-1:0]      CONV_VALUE,
	output logic                                 NORMAL_HW_START,
	output logic                                 PRIORITY_HW_START,
	output logic                                 SOFT_RESET,
	output logic                                 IRQ
);
	import adcs_pkg::*;

	// =====================================================================
	// bus slave state
	adcs_wr_state_type       wr_state_q;
	adcs_rd_state_type       rd_state_q;
	logic                    awready_q;
	logic                    wready_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    arready_q;
	logic                    rvalid_q;
	logic [1:0]              rresp_q;
	logic [31:0]             rdata_q;
	logic [ADDR_W-1:0]       waddr_q;
	logic [7:0]              wdata_q;
	logic                    wlane_q;
	logic [ADDR_W-1:0]       raddr_q;

	// =====================================================================
	// block state
	logic                    pri_sel_q;
	logic                    pri_en_q;
	logic                    nrm_sel_q;
	logic                    nrm_en_q;
	logic                    key_armed_q;
	logic                    soft_reset_q;
	logic [IRQ_W-1:0]        irq_stat_q;
	logic [IRQ_W-1:0]        irq_stat_d;
	logic [IRQ_W-1:0]        irq_mask_q;
	logic                    irq_q;

	// =====================================================================
	// handshakes
	wire aw_hs = S_AXI_AWVALID & awready_q;
	wire w_hs  = S_AXI_WVALID & wready_q;
	wire ar_hs = S_AXI_ARVALID & arready_q;

	// the register write and read effects take place in the EXEC cycles only
	wire wr_en = (wr_state_q == WR_EXEC);
	wire rd_en = (rd_state_q == RD_EXEC);

	// =====================================================================
	// write address decode
	wire wr_ctrl = (waddr_q == reg_byte_addr(OFF_CTRL));
	wire wr_stat = (waddr_q == reg_byte_addr(OFF_IRQ_STAT));
	wire wr_mask = (waddr_q == reg_byte_addr(OFF_IRQ_MASK));

	wire [NUM_PAIRS-1:0] wr_pair_hit;
	wire [NUM_PAIRS-1:0] rd_lo_hit;
	wire [NUM_PAIRS-1:0] rd_hi_hit;
	wire [NUM_PAIRS-1:0] rd_lo_pulse;
	wire [NUM_PAIRS-1:0] rd_hi_pulse;
	wire [NUM_PAIRS-1:0] pair_load;
	wire [NUM_PAIRS-1:0] pair_ovr_set;
	wire [7:0]           pair_rd [NUM_PAIRS];

	// result registers are read-only but a write to them still answers OKAY
	wire wr_known = wr_ctrl | wr_stat | wr_mask | (|wr_pair_hit);

	// writes land only through byte lane 0; the upper lanes hold nothing
	wire wr_lane0   = wr_en & wlane_q;
	wire ctrl_write = wr_lane0 & wr_ctrl;
	wire key_first  = ctrl_write & (wdata_q[1:0] == KEY_FIRST);
	wire key_second = ctrl_write & (wdata_q[1:0] == KEY_SECOND) & key_armed_q;

	// =====================================================================
	// read address decode
	wire rd_ctrl = (raddr_q == reg_byte_addr(OFF_CTRL));
	wire rd_stat = (raddr_q == reg_byte_addr(OFF_IRQ_STAT));
	wire rd_mask = (raddr_q == reg_byte_addr(OFF_IRQ_MASK));
	wire rd_known = rd_ctrl | rd_stat | rd_mask | (|rd_lo_hit) | (|rd_hi_hit);

	// key field is write-only and reads as zero, like bits 3:2
	wire [7:0] ctrl_rd = {pri_sel_q, pri_en_q, nrm_sel_q, nrm_en_q, 4'h0};
	wire [7:0] res_rd  = pair_rd[0] | pair_rd[1] | pair_rd[2];
	wire [7:0] reg_rd  = rd_ctrl ? ctrl_rd :
	                     rd_stat ? {4'h0, irq_stat_q} :
	                     rd_mask ? {4'h0, irq_mask_q} :
	                     res_rd;

	// =====================================================================
	// result pairs
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
			logic [7:0] lo_byte;
			logic [7:0] hi_byte;

			assign wr_pair_hit[gi] = (waddr_q == reg_byte_addr(OFF_RES_LO[gi])) |
			                         (waddr_q == reg_byte_addr(OFF_RES_HI[gi]));
			assign rd_lo_hit[gi]   = (raddr_q == reg_byte_addr(OFF_RES_LO[gi]));
			assign rd_hi_hit[gi]   = (raddr_q == reg_byte_addr(OFF_RES_HI[gi]));
			assign rd_lo_pulse[gi] = rd_en & rd_lo_hit[gi];  // see [R10] see [R12]
			assign rd_hi_pulse[gi] = rd_en & rd_hi_hit[gi];
			// pair code 3 has no register pair and is dropped
			assign pair_load[gi]   = CONV_LOAD & (CONV_PAIR == 2'(gi));  // see [R9]
			assign pair_rd[gi]     = ({8{rd_lo_hit[gi]}} & lo_byte) | ({8{rd_hi_hit[gi]}} & hi_byte);

			adcs_result_pair u_pair (
				.clk     (CLOCK),
				.rst_n   (RST_N),
				.load    (pair_load[gi]),
				.value   (CONV_VALUE),
				.rd_lo   (rd_lo_pulse[gi]),
				.rd_hi   (rd_hi_pulse[gi]),
				.lo_byte (lo_byte),
				.hi_byte (hi_byte),
				.ovr_set (pair_ovr_set[gi])
			);
		end
	endgenerate

	// =====================================================================
	// hardware start paths
	// a soft reset cycle swallows any edge so a source switch starts clean
	adcs_hw_trigger u_nrm_trig (
		.clk       (CLOCK),
		.rst_n     (RST_N),
		.enable    (nrm_en_q),  // see [R1]
		.src_timer (nrm_sel_q),  // see [R2]
		.ext_pin   (EXTERNAL_CONV_TRIGGER),  // see [R3] see [R6]
		.timer_irq (TIMER0_IRQ),
		.block     (soft_reset_q),  // see [R5]
		.start_q   (NORMAL_HW_START)
	);

	adcs_hw_trigger u_pri_trig (
		.clk       (CLOCK),
		.rst_n     (RST_N),
		.enable    (pri_en_q),  // see [R1]
		.src_timer (pri_sel_q),  // see [R2]
		.ext_pin   (EXTERNAL_CONV_TRIGGER),
		.timer_irq (TIMER1_IRQ),  // see [R4]
		.block     (soft_reset_q),
		.start_q   (PRIORITY_HW_START)
	);

	// =====================================================================
	// control register and soft reset key
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pri_sel_q <= 1'b0;
			pri_en_q  <= 1'b0;
			nrm_sel_q <= 1'b0;
			nrm_en_q  <= 1'b0;
		end else if (ctrl_write) begin
			pri_sel_q <= wdata_q[PRI_SEL_BIT];
			pri_en_q  <= wdata_q[PRI_EN_BIT];
			nrm_sel_q <= wdata_q[NRM_SEL_BIT];
			nrm_en_q  <= wdata_q[NRM_EN_BIT];
		end
	end

	// any control write other than the first key disarms the sequence
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			key_armed_q  <= 1'b0;
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= key_second;  // see [R13]
			if (ctrl_write) begin
				key_armed_q <= key_first;  // see [R13]
			end
		end
	end

	assign SOFT_RESET = soft_reset_q;

	// =====================================================================
	// interrupt status, mask and output
	// a new event outweighs a write-one-to-clear in the same cycle
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_lane0 & wr_stat) begin
			irq_stat_d = irq_stat_d & ~wdata_q[IRQ_W-1:0];
		end
		irq_stat_d[IRQ_NRM_START] = irq_stat_d[IRQ_NRM_START] | NORMAL_HW_START;
		irq_stat_d[IRQ_PRI_START] = irq_stat_d[IRQ_PRI_START] | PRIORITY_HW_START;
		irq_stat_d[IRQ_STORED]    = irq_stat_d[IRQ_STORED] | (|pair_load);
		irq_stat_d[IRQ_OVERRUN]   = irq_stat_d[IRQ_OVERRUN] | (|pair_ovr_set);
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_lane0 & wr_mask) begin
				irq_mask_q <= wdata_q[IRQ_W-1:0];
			end
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign IRQ = irq_q;

	// =====================================================================
	// AXI4-Lite write channel
	// address and data are taken in either order; one write in flight
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			wr_state_q <= WR_IDLE;
			awready_q  <= 1'b1;
			wready_q   <= 1'b1;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			waddr_q    <= '0;
			wdata_q    <= '0;
			wlane_q    <= 1'b0;
		end else begin
			if (aw_hs) begin
				waddr_q   <= S_AXI_AWADDR;
				awready_q <= 1'b0;
			end
			if (w_hs) begin
				wdata_q  <= S_AXI_WDATA[7:0];
				wlane_q  <= S_AXI_WSTRB[0];
				wready_q <= 1'b0;
			end
			unique case (wr_state_q)
				WR_IDLE: begin
					if (aw_hs & w_hs) begin
						wr_state_q <= WR_EXEC;
					end else if (aw_hs) begin
						wr_state_q <= WR_HAVE_ADDR;
					end else if (w_hs) begin
						wr_state_q <= WR_HAVE_DATA;
					end
				end
				WR_HAVE_ADDR: begin
					if (w_hs) begin
						wr_state_q <= WR_EXEC;
					end
				end
				WR_HAVE_DATA: begin
					if (aw_hs) begin
						wr_state_q <= WR_EXEC;
					end
				end
				WR_EXEC: begin
					bvalid_q   <= 1'b1;
					bresp_q    <= wr_known ? RESP_OKAY : RESP_SLVERR;
					wr_state_q <= WR_RESP;
				end
				WR_RESP: begin
					if (S_AXI_BREADY) begin
						bvalid_q   <= 1'b0;
						awready_q  <= 1'b1;
						wready_q   <= 1'b1;
						wr_state_q <= WR_IDLE;
					end
				end
			endcase
		end
	end

	// =====================================================================
	// AXI4-Lite read channel
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			rd_state_q <= RD_IDLE;
			arready_q  <= 1'b1;
			rvalid_q   <= 1'b0;
			rresp_q    <= RESP_OKAY;
			rdata_q    <= '0;
			raddr_q    <= '0;
		end else begin
			unique case (rd_state_q)
				RD_IDLE: begin
					if (ar_hs) begin
						raddr_q    <= S_AXI_ARADDR;
						arready_q  <= 1'b0;
						rd_state_q <= RD_EXEC;
					end
				end
				RD_EXEC: begin
					rdata_q    <= rd_known ? {24'h0, reg_rd} : '0;
					rresp_q    <= rd_known ? RESP_OKAY : RESP_SLVERR;
					rvalid_q   <= 1'b1;
					rd_state_q <= RD_RESP;
				end
				RD_RESP: begin
					if (S_AXI_RREADY) begin
						rvalid_q   <= 1'b0;
						arready_q  <= 1'b1;
						rd_state_q <= RD_IDLE;
					end
				end
			endcase
		end
	end

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RRESP   = rresp_q;
	assign S_AXI_RDATA   = rdata_q;

endmodule : adcs_top

// ===== tb/adcs_top_assertions.sv
/*
 * adcs_top_assertions: concurrent checks on the ports of adcs_top.
 * assumes: bound to adcs_top below, single clock domain, inputs low in reset.
 */
`timescale 1ns/100ps
module adcs_top_assertions (
	input wire logic                        CLOCK,
	input wire logic                        RST_N,
	input wire logic                        S_AXI_AWVALID,
	input wire logic                        S_AXI_AWREADY,
	input wire logic                        S_AXI_WVALID,
	input wire logic                        S_AXI_WREADY,
	input wire logic [1:0]                  S_AXI_BRESP,
	input wire logic                        S_AXI_BVALID,
	input wire logic [adcs_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic                        S_AXI_ARVALID,
	input wire logic                        S_AXI_ARREADY,
	input wire logic [31:0]                 S_AXI_RDATA,
	input wire logic [1:0]                  S_AXI_RRESP,
	input wire logic                        S_AXI_RVALID,
	input wire logic                        EXTERNAL_CONV_TRIGGER,
	input wire logic                        TIMER0_IRQ,
	input wire logic                        TIMER1_IRQ,
	input wire logic                        NORMAL_HW_START,
	input wire logic                        PRIORITY_HW_START,
	input wire logic                        SOFT_RESET,
	input wire logic                        IRQ
);
	import adcs_pkg::*;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	// ==========
	// address of the read in flight, held until its data phase
	logic [ADDR_W-1:0] ar_q;
	logic              lo_sel;
	logic              mapped;
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			ar_q <= '0;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			ar_q <= S_AXI_ARADDR;
	end
	assign lo_sel = ar_q inside {8'h00, 8'h08, 8'h10};
	assign mapped = lo_sel || (ar_q inside {8'h04, 8'h0c, 8'h14, 8'h70, 8'h80, 8'h84});

	// ==========
	// properties
	property p_reset_out;
		$rose(RST_N) |-> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ && !SOFT_RESET && !NORMAL_HW_START;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
	property p_nrm_start;
		NORMAL_HW_START |-> (($past(TIMER0_IRQ) && !$past(TIMER0_IRQ, 2))
			|| ($past(EXTERNAL_CONV_TRIGGER) && !$past(EXTERNAL_CONV_TRIGGER, 2))) ##1 !NORMAL_HW_START;
	endproperty
	a_nrm_start: assert property (p_nrm_start) else $error("normal start without source edge");
	property p_pri_start;
		PRIORITY_HW_START |-> (($past(TIMER1_IRQ) && !$past(TIMER1_IRQ, 2))
			|| ($past(EXTERNAL_CONV_TRIGGER) && !$past(EXTERNAL_CONV_TRIGGER, 2))) ##1 !PRIORITY_HW_START;
	endproperty
	a_pri_start: assert property (p_pri_start) else $error("priority start without source edge");
	property p_soft;
		SOFT_RESET |-> (S_AXI_BVALID && S_AXI_BRESP == RESP_OKAY) ##1 !SOFT_RESET;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset not tied to a write");
	property p_fill;
		S_AXI_RVALID && lo_sel |-> S_AXI_RDATA[5:2] == LO_FILL && S_AXI_RDATA[31:8] == 24'h0;
	endproperty
	a_fill: assert property (p_fill) else $error("low result fill bits wrong");
	property p_slverr;
		S_AXI_RVALID && !mapped |-> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
	property p_wr_lat;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response late");
	property p_rd_lat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_ARREADY ##1 S_AXI_RVALID;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
endmodule : adcs_top_assertions

bind adcs_top adcs_top_assertions u_adcs_top_assertions (.*);

// ===== tb/adcs_top_tb.sv
/*
 * adcs_top_tb: self-checking bench for adcs_top; reads are noted in a queue and judged by a monitor.
 * assumes: adcs_pkg, the design and the checker compiled first.
 */
`timescale 1ns/100ps
module adcs_top_tb;
	import adcs_pkg::*;
	logic                    CLOCK = 1'h0, RST_N = 1'h0;
	logic [ADDR_W-1:0]       S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0]             S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0]              S_AXI_WSTRB = 4'h0;
	logic [1:0]              S_AXI_BRESP, S_AXI_RRESP, CONV_PAIR = 2'h0, resp;
	logic                    S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic                    S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, CONV_LOAD = 1'h0;
	logic                    S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic                    EXTERNAL_CONV_TRIGGER = 1'h0, TIMER0_IRQ = 1'h0, TIMER1_IRQ = 1'h0;
	logic [RES_W-1:0]        CONV_VALUE = 10'h0, v, w;
	logic                    NORMAL_HW_START, PRIORITY_HW_START, SOFT_RESET, IRQ;
	logic [33:0]             exp_q[$];
	logic [31:0]             rng = 32'd45925;
	logic [7:0]              ctrl;
	int                      n_fail = 0, tests_run = 0, n_soft = 0, n_nrm = 0, n_pri = 0;

	adcs_top u_adcs_top (.*);
	always #20 CLOCK = ~CLOCK;

	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [7:0] lo(input logic [9:0] x, input logic o, input logic s);
		return {x[1:0], 4'hf, o, s};
	endfunction : lo
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
		@(posedge CLOCK);
		S_AXI_AWADDR  <= a;
		S_AXI_WDATA   <= {24'h0, d};
		S_AXI_WSTRB   <= s;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID  <= 1'h1;
		S_AXI_BREADY  <= 1'h1;
		do begin
			@(posedge CLOCK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
		end while (S_AXI_BVALID !== 1'h1);
		resp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		@(posedge CLOCK);
		exp_q.push_back({r, 24'h0, d});
		S_AXI_ARADDR  <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY  <= 1'h1;
		do begin
			@(posedge CLOCK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
		end while (S_AXI_RVALID !== 1'h1);
		S_AXI_RREADY <= 1'h0;
	endtask : rd
	task automatic load(input logic [1:0] p, output logic [9:0] val);
		@(posedge CLOCK);
		rng = xs(rng);
		val = rng[9:0];
		CONV_PAIR  <= p;
		CONV_VALUE <= val;
		CONV_LOAD  <= 1'h1;
		@(posedge CLOCK);
		CONV_LOAD <= 1'h0;
	endtask : load
	// k: 0 trigger pin, 1 timer 0, 2 timer 1
	task automatic pulse(input int k);
		@(posedge CLOCK);
		EXTERNAL_CONV_TRIGGER <= (k == 0);
		TIMER0_IRQ            <= (k == 1);
		TIMER1_IRQ            <= (k == 2);
		@(posedge CLOCK);
		EXTERNAL_CONV_TRIGGER <= 1'h0;
		TIMER0_IRQ            <= 1'h0;
		TIMER1_IRQ            <= 1'h0;
		repeat (3) @(posedge CLOCK);
	endtask : pulse

	// ==========
	// monitor: each read answer against the oldest note
	always @(posedge CLOCK) begin
		if (S_AXI_RVALID === 1'h1 && S_AXI_RREADY === 1'h1)
			check({S_AXI_RRESP, S_AXI_RDATA}, exp_q.pop_front());
		if (SOFT_RESET === 1'h1)
			n_soft++;
		if (NORMAL_HW_START === 1'h1)
			n_nrm++;
		if (PRIORITY_HW_START === 1'h1)
			n_pri++;
	end
	initial begin
		#(40 * 8000);
		n_fail++;
		stop_test();
	end

	// ==========
	// main sequence
	initial begin
		repeat (16) @(posedge CLOCK);
		RST_N <= 1'h1;
		rd(8'h70, 8'h00);
		rd(8'h80, 8'h00);
		rd(8'h40, 8'h00, RESP_SLVERR);
		$display("reset test done");
		for (int p = 0; p < 3; p++) begin
			load(p, v);
			rd(8 * p, lo(v, 1'h0, 1'h1));
			rd(8 * p + 4, v[9:2]);
			rd(8 * p, lo(v, 1'h0, 1'h0));
			load(p, v);
			load(p, w);
			rd(8 * p, lo(w, 1'h1, 1'h1));
			rd(8 * p, lo(w, 1'h0, 1'h0));
			// upper half still unread from the loads above
			load(p, v);
			rd(8 * p, lo(v, 1'h1, 1'h1));
			rd(8 * p + 4, v[9:2]);
			// both halves read, then only the upper half before the next load
			load(p, v);
			rd(8 * p + 4, v[9:2]);
			load(p, w);
			rd(8 * p, lo(w, 1'h1, 1'h1));
			rd(8 * p + 4, w[9:2]);
			load(p, v);
			load(2'h3, w);
			wr(8 * p + 4, 8'h55);
			check({32'h0, resp}, {32'h0, RESP_OKAY});
			rd(8 * p + 4, v[9:2]);
			rd(8 * p, lo(v, 1'h0, 1'h1));
		end
		$display("result test done");
		rd(8'h80, 8'h0c);
		wr(8'h80, 8'h0f);
		rd(8'h80, 8'h00);
		wr(8'h84, 8'h04);
		load(2'h0, v);
		repeat (2) @(posedge CLOCK);
		check({33'h0, IRQ}, 34'h1);
		wr(8'h84, 8'h00);
		@(posedge CLOCK);
		check({33'h0, IRQ}, 34'h0);
		wr(8'h80, 8'h0f);
		wr(8'h84, 8'h0f);
		@(posedge CLOCK);
		check({33'h0, IRQ}, 34'h0);
		$display("interrupt test done");
		for (int k = 0; k < 4; k++) begin
			ctrl = k[1] ? {k[0], 7'h00} : {2'h0, k[0], 5'h00};
			wr(8'h70, ctrl | 8'h02);
			wr(8'h70, ctrl | 8'h01);
			wr(8'h80, 8'h0f);
			pulse(k[0] ? k[1] + 1 : 0);
			rd(8'h80, 8'h00);
			ctrl = ctrl | (k[1] ? 8'h40 : 8'h10);
			wr(8'h70, ctrl);
			rd(8'h70, ctrl);
			// the unselected source of the same start path must be ignored
			pulse(k[0] ? 0 : k[1] + 1);
			rd(8'h80, 8'h00);
			pulse(k[0] ? k[1] + 1 : 0);
			rd(8'h80, k[1] ? 8'h02 : 8'h01);
			wr(8'h70, 8'h00);
		end
		check(n_soft, 4);
		check({n_pri[16:0], n_nrm[16:0]}, {17'd2, 17'd2});
		wr(8'h70, 8'h02);
		wr(8'h70, 8'h00);
		wr(8'h70, 8'h01);
		wr(8'h70, 8'hf0, 4'h0);
		rd(8'h70, 8'h00);
		wr(8'h44, 8'h01);
		check({32'h0, resp}, {32'h0, RESP_SLVERR});
		@(posedge CLOCK);
		check(n_soft, 4);
		$display("start source test done");
		repeat (4) @(posedge CLOCK);
		stop_test();
	end
endmodule : adcs_top_tb
